// [hdl/g703_pkg.sv]
// Purpose: Shared constants and types for the 64 kbps co-directional line interface
// Assumes: ref_clk at 125 MHz
// Notes:   Line rate is fixed; there is no rate setting anywhere in the block
package g703_pkg;

   // Clock and line timing
   localparam int CLK_PERIOD_PS  = 8000;
   localparam int LINE_RATE_BPS  = 64000;
   localparam int BIT_PERIOD_NS  = 15625;
   // Longest time, so rounded down to whole cycles
   localparam int BIT_CYCLES_INT = (BIT_PERIOD_NS * 1000) / CLK_PERIOD_PS;
   localparam int DIV_W          = 11;
   localparam logic [DIV_W-1:0] BIT_CYCLES_LAST = DIV_W'(BIT_CYCLES_INT - 1);
   localparam logic [DIV_W-1:0] BIT_CYCLES_HALF = DIV_W'(BIT_CYCLES_INT / 2);

   // Octet framing
   localparam int         OCTET_BITS     = 8;
   localparam logic [2:0] OCTET_LAST_BIT = 3'h7;
   localparam logic [2:0] OCTET_RESET    = 3'h7;

   // Synchroniser and buffering
   localparam int SYNC_IN_CNT = 5;
   localparam int SYNC_OCT    = 0;
   localparam int SYNC_SELA   = 1;
   localparam int SYNC_SELB   = 2;
   localparam int SYNC_RXCLK  = 3;
   localparam int SYNC_RXDATA = 4;
   localparam int FIFO_WIDTH  = 1;
   localparam int FIFO_DEPTH  = 8;

   // Line idles at mark when nothing is queued
   localparam logic IDLE_BIT = 1'h1;

   // Operating modes, index is {selectB, selectA}
   typedef enum logic [1:0]
   {
      MODE_LOOP      = 2'b00,
      MODE_INTERNAL  = 2'b01,
      MODE_REMOTE_LB = 2'b10,
      MODE_DUAL_LB   = 2'b11
   } mode_t;

endpackage

// [hdl/codirectional_64k_line_interface.sv]
// Purpose: Joins the internal Differential Manchester bit stream to a 64 kbps co-directional line
// Assumes: Line pins and selection switches are asynchronous to ref_clk
// Notes:   Switches are read all the time; change them only while in reset
// Contract
// - Line runs at 64 kbps only
// - Octet pulse on bit 8 when enabled
// - Two switches pick one of four modes
// - Internal mode times transmit from own clock
// - Loop mode times transmit from received line
// - Remote loopback latches line data, returns it
// - Remote loopback: decode forwarded, internal discarded
// - Dual loopback returns internal data internally
// - Dual loopback returns line data to line
`timescale 1ns/1ps

module bit_fifo
#(
   parameter int WIDTH = 1,
   parameter int DEPTH = 8
)
(
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] inData,
   input  wire logic             inValid,
   output logic                  inReady,
   output logic      [WIDTH-1:0] outData,
   output logic                  outValid,
   input  wire logic             outReady
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
   localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wrPtr_r;
   logic [PW-1:0]    wrPtr_nxt;
   logic [PW-1:0]    rdPtr_r;
   logic [PW-1:0]    rdPtr_nxt;
   logic [CW-1:0]    count_r;
   logic [CW-1:0]    count_nxt;
   logic             notFull_r;
   logic             notFull_nxt;
   logic             notEmpty_r;
   logic             notEmpty_nxt;
   logic             doWrite;
   logic             doRead;

   always_comb
   begin
      doWrite      = inValid & notFull_r;
      doRead       = outReady & notEmpty_r;
      wrPtr_nxt    = wrPtr_r;
      rdPtr_nxt    = rdPtr_r;
      count_nxt    = count_r;
      if (doWrite)
         wrPtr_nxt = (wrPtr_r == PTR_LAST) ? '0 : wrPtr_r + PW'(1);
      if (doRead)
         rdPtr_nxt = (rdPtr_r == PTR_LAST) ? '0 : rdPtr_r + PW'(1);
      if (doWrite && !doRead)
         count_nxt = count_r + CW'(1);
      else if (doRead && !doWrite)
         count_nxt = count_r - CW'(1);
      // Flags registered so both handshake outputs come from flops
      notFull_nxt  = (count_nxt != CNT_FULL);
      notEmpty_nxt = (count_nxt != '0);
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wrPtr_r    <= '0;
         rdPtr_r    <= '0;
         count_r    <= '0;
         notFull_r  <= 1'h1;
         notEmpty_r <= 1'h0;
      end
      else
      begin
         wrPtr_r    <= wrPtr_nxt;
         rdPtr_r    <= rdPtr_nxt;
         count_r    <= count_nxt;
         notFull_r  <= notFull_nxt;
         notEmpty_r <= notEmpty_nxt;
      end
   end

   // Storage has no reset; contents are only read when the count says so
   always_ff @(posedge ref_clk)
   begin
      if (doWrite)
         mem[wrPtr_r] <= inData;
   end

   assign inReady  = notFull_r;
   assign outValid = notEmpty_r;
   assign outData  = mem[rdPtr_r];

endmodule // bit_fifo

module codirectional_64k_line_interface
(
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic octetTimingSwitch,
   input  wire logic timingModeSelectA,
   input  wire logic timingModeSelectB,
   input  wire logic lineRxClk,
   input  wire logic lineRxData,
   output logic      lineTxClk,
   output logic      lineTxData,
   output logic      lineOctetTiming,
   input  wire logic dmInBit,
   input  wire logic dmInValid,
   output logic      dmInReady,
   output logic      dmOutBit,
   output logic      dmOutValid,
   output logic [1:0] activeMode
);

   // Switch and pin synchronisers
   logic [g703_pkg::SYNC_IN_CNT-1:0] syncRaw;
   logic [g703_pkg::SYNC_IN_CNT-1:0] sync1_r;
   logic [g703_pkg::SYNC_IN_CNT-1:0] sync2_r;

   assign syncRaw = {lineRxData, lineRxClk, timingModeSelectB, timingModeSelectA, octetTimingSwitch};

   genvar gi;
   generate
      for (gi = 0; gi < g703_pkg::SYNC_IN_CNT; gi++)
      begin : gSync
         always_ff @(posedge ref_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               sync1_r[gi] <= 1'h0;
               sync2_r[gi] <= 1'h0;
            end
            else
            begin
               sync1_r[gi] <= syncRaw[gi];
               sync2_r[gi] <= sync1_r[gi];
            end
         end
      end
   endgenerate

   function automatic g703_pkg::mode_t decodeMode(input logic selA, input logic selB);
      g703_pkg::mode_t m;
      case ({selB, selA})
         2'b00:   m = g703_pkg::MODE_LOOP;
         2'b01:   m = g703_pkg::MODE_INTERNAL;
         2'b10:   m = g703_pkg::MODE_REMOTE_LB;
         default: m = g703_pkg::MODE_DUAL_LB;
      endcase
      return m;
   endfunction

   // Buffer between internal receiver and line transmitter
   logic fifoInReady;
   logic fifoOutBit;
   logic fifoOutValid;
   logic fifoPop;

   bit_fifo
   #(
      .WIDTH (g703_pkg::FIFO_WIDTH),
      .DEPTH (g703_pkg::FIFO_DEPTH)
   )
   uFifo
   (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .inData   (dmInBit),
      .inValid  (dmInValid),
      .inReady  (fifoInReady),
      .outData  (fifoOutBit),
      .outValid (fifoOutValid),
      .outReady (fifoPop)
   );

   // Datapath state
   g703_pkg::mode_t               mode;
   logic                          rxClkD_r;
   logic                          rxRise;
   logic                          rxFall;
   logic [g703_pkg::DIV_W-1:0]    divCnt_r;
   logic [g703_pkg::DIV_W-1:0]    divCnt_nxt;
   logic                          divTick;
   logic                          txTick;
   logic                          rxLatch_r;
   logic                          rxLatch_nxt;
   logic                          rxNew_r;
   logic                          rxNew_nxt;
   logic [2:0]                    bitCnt_r;
   logic [2:0]                    bitCnt_nxt;
   logic                          txClk_r;
   logic                          txClk_nxt;
   logic                          txData_r;
   logic                          txData_nxt;
   logic                          octet_r;
   logic                          octet_nxt;
   logic                          outBit_r;
   logic                          outBit_nxt;
   logic                          outValid_r;
   logic                          outValid_nxt;
   logic [1:0]                    mode_r;

   always_comb
   begin
      mode       = decodeMode(sync2_r[g703_pkg::SYNC_SELA], sync2_r[g703_pkg::SYNC_SELB]);
      rxRise     = sync2_r[g703_pkg::SYNC_RXCLK] & ~rxClkD_r;
      rxFall     = ~sync2_r[g703_pkg::SYNC_RXCLK] & rxClkD_r;

      // Free-running bit divider, always one line bit of 64 kbps
      divTick    = (divCnt_r == g703_pkg::BIT_CYCLES_LAST);
      divCnt_nxt = divTick ? '0 : divCnt_r + g703_pkg::DIV_W'(1);

      // Transmit timing source; loop and both loopbacks follow the received line clock
      if (mode == g703_pkg::MODE_INTERNAL)
         txTick = divTick;
      else
         txTick = rxRise;

      // Stabilising latch on received line data, captured on line clock rise
      rxLatch_nxt = rxRise ? sync2_r[g703_pkg::SYNC_RXDATA] : rxLatch_r;
      rxNew_nxt   = rxRise;

      // Dual loopback drains the buffer back inside; remote loopback pops at bit time and drops
      if (mode == g703_pkg::MODE_DUAL_LB)
         fifoPop = 1'h1;
      else
         fifoPop = txTick;

      // Line transmitter
      txClk_nxt  = txClk_r;
      txData_nxt = txData_r;
      bitCnt_nxt = bitCnt_r;
      octet_nxt  = octet_r;
      if (txTick)
      begin
         txClk_nxt  = 1'h1;
         bitCnt_nxt = bitCnt_r + 3'h1;
         if (mode == g703_pkg::MODE_REMOTE_LB || mode == g703_pkg::MODE_DUAL_LB)
         begin
            txData_nxt = rxLatch_nxt;
         end
         else if (fifoOutValid)
         begin
            txData_nxt = fifoOutBit;
         end
         else
         begin
            txData_nxt = g703_pkg::IDLE_BIT;
         end
         // Marks the eighth bit of every octet, off when the switch is off
         octet_nxt = sync2_r[g703_pkg::SYNC_OCT] & (bitCnt_nxt == g703_pkg::OCTET_LAST_BIT);
      end
      else if (mode == g703_pkg::MODE_INTERNAL)
      begin
         if (divCnt_r == g703_pkg::BIT_CYCLES_HALF)
         begin
            txClk_nxt = 1'h0;
         end
      end
      else if (rxFall)
      begin
         txClk_nxt = 1'h0;
      end

      // Internal transmitter feed
      outBit_nxt   = outBit_r;
      outValid_nxt = 1'h0;
      if (mode == g703_pkg::MODE_DUAL_LB)
      begin
         if (fifoOutValid)
         begin
            outBit_nxt   = fifoOutBit;
            outValid_nxt = 1'h1;
         end
      end
      else if (rxNew_r)
      begin
         // Line data reaches the inside in every other mode, remote loopback included
         outBit_nxt   = rxLatch_r;
         outValid_nxt = 1'h1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rxClkD_r   <= 1'h0;
         divCnt_r   <= '0;
         rxLatch_r  <= 1'h0;
         rxNew_r    <= 1'h0;
         bitCnt_r   <= g703_pkg::OCTET_RESET;
         txClk_r    <= 1'h0;
         txData_r   <= g703_pkg::IDLE_BIT;
         octet_r    <= 1'h0;
         outBit_r   <= 1'h0;
         outValid_r <= 1'h0;
         mode_r     <= g703_pkg::MODE_LOOP;
      end
      else
      begin
         rxClkD_r   <= sync2_r[g703_pkg::SYNC_RXCLK];
         divCnt_r   <= divCnt_nxt;
         rxLatch_r  <= rxLatch_nxt;
         rxNew_r    <= rxNew_nxt;
         bitCnt_r   <= bitCnt_nxt;
         txClk_r    <= txClk_nxt;
         txData_r   <= txData_nxt;
         octet_r    <= octet_nxt;
         outBit_r   <= outBit_nxt;
         outValid_r <= outValid_nxt;
         mode_r     <= mode;
      end
   end

   assign lineTxClk       = txClk_r;
   assign lineTxData      = txData_r;
   assign lineOctetTiming = octet_r;
   assign dmInReady       = fifoInReady;
   assign dmOutBit        = outBit_r;
   assign dmOutValid      = outValid_r;
   assign activeMode      = mode_r;

endmodule // codirectional_64k_line_interface

// [bench/line_partner.sv]
// Purpose: Far end of the 64 kbps line, supplies its own bit clock
// Assumes: Bench link clock period of 80 ns
// Notes:   Clock stands at 0 between frames
`timescale 1ns/1ps
module line_partner
(
   output logic lineRxClk,
   output logic lineRxData
);
   initial
   begin
      lineRxClk  = 1'b0;
      lineRxData = 1'b0;
   end
   // Far end always times the line, loopback or not
   task automatic send_bit(input logic b);
      lineRxData = b;
      #40 lineRxClk = 1'b1;
      #40 lineRxClk = 1'b0;
   endtask
   // Undriven pair: show the opposite of the last bit so stale data is not trusted
   task automatic end_frame();
      lineRxData = ~lineRxData;
   endtask
endmodule // line_partner

// [bench/codirectional_64k_line_interface_chk.sv]
// Purpose: Port-level assertions for the line interface
// Assumes: Switches only change while in reset
// Notes:   Bound to the top module
`timescale 1ns/1ps
module codirectional_64k_line_interface_chk
(
   input wire logic       ref_clk,
   input wire logic       rst_n,
   input wire logic       octetTimingSwitch,
   input wire logic       timingModeSelectA,
   input wire logic       timingModeSelectB,
   input wire logic       lineRxClk,
   input wire logic       lineRxData,
   input wire logic       lineTxClk,
   input wire logic       lineTxData,
   input wire logic       lineOctetTiming,
   input wire logic       dmInBit,
   input wire logic       dmInValid,
   input wire logic       dmInReady,
   input wire logic       dmOutBit,
   input wire logic       dmOutValid,
   input wire logic [1:0] activeMode
);
   logic [10:0] cnt_r;
   logic [10:0] cnt_nxt;
   logic        seen_r;
   logic        seen_nxt;
   logic        txPrev_r;
   always_comb
   begin
      cnt_nxt  = (lineTxClk && !txPrev_r) ? 11'h0 : cnt_r + 11'h1;
      seen_nxt = seen_r || (lineTxClk && !txPrev_r);
   end
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_r    <= 11'h0;
         seen_r   <= 1'b0;
         txPrev_r <= 1'b0;
      end
      else
      begin
         cnt_r    <= cnt_nxt;
         seen_r   <= seen_nxt;
         txPrev_r <= lineTxClk;
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence rxEdge;
      $rose(lineRxClk);
   endsequence
   sequence dmTaken;
      dmInValid && dmInReady;
   endsequence
   a_mode_decode: assert property ($stable({timingModeSelectB, timingModeSelectA})[*4]
      |-> activeMode == {timingModeSelectB, timingModeSelectA}) else $error("mode output wrong");
   a_int_period: assert property (activeMode == 2'b01 && $rose(lineTxClk) && seen_r |-> cnt_r == 11'h7a0)
      else $error("internal bit period wrong");
   // Two sync stages, edge detect, then the tick register: seen three samples after the pin edge
   a_loop_follow: assert property (activeMode != 2'b01 ##0 rxEdge |-> ##3 $rose(lineTxClk))
      else $error("tx clock not following line");
   a_line_echo: assert property (activeMode[1] ##0 rxEdge |-> ##3 lineTxData == $past(lineRxData, 3))
      else $error("line data not returned");
   a_rx_forward: assert property (activeMode != 2'b11 ##0 rxEdge
      |-> ##4 dmOutValid && dmOutBit == $past(lineRxData, 4)) else $error("line bit not forwarded");
   a_dual_return: assert property (activeMode == 2'b11 ##0 dmTaken
      |-> ##2 dmOutValid && dmOutBit == $past(dmInBit, 2)) else $error("internal bit not returned");
   a_dual_quiet: assert property (activeMode == 2'b11 && !$past(dmInValid) && !$past(dmInValid, 2)
      |-> !dmOutValid) else $error("line data leaked inside");
   a_octet_tx: assert property ($rose(lineOctetTiming) |-> $rose(lineTxClk) && octetTimingSwitch)
      else $error("octet mark misplaced");
   a_tx_change: assert property (!$stable(lineTxData) |-> $rose(lineTxClk))
      else $error("tx data moved off clock");
endmodule // codirectional_64k_line_interface_chk
bind codirectional_64k_line_interface codirectional_64k_line_interface_chk i_chk (.ref_clk, .rst_n,
   .octetTimingSwitch, .timingModeSelectA, .timingModeSelectB, .lineRxClk, .lineRxData, .lineTxClk,
   .lineTxData, .lineOctetTiming, .dmInBit, .dmInValid, .dmInReady, .dmOutBit, .dmOutValid, .activeMode);

// [bench/codirectional_64k_line_interface_test.sv]
// Purpose: Walks all four modes with FIFO fill and line traffic
// Assumes: Reset between modes, switches static
// Notes:   Internal mode waits ten real bit periods
`timescale 1ns/1ps
module codirectional_64k_line_interface_test;
   logic ref_clk, rst_n, octetTimingSwitch, timingModeSelectA, timingModeSelectB;
   logic lineRxClk, lineRxData, lineTxClk, lineTxData, lineOctetTiming;
   logic dmInBit, dmInValid, dmInReady, dmOutBit, dmOutValid;
   logic txPrev = 1'b0;
   logic [1:0] activeMode;
   logic expDm[$];
   logic expLine[$];
   int errCount, nTests, txCount;
   int seed = 32'h14c4;
   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   codirectional_64k_line_interface i_dut (.ref_clk, .rst_n, .octetTimingSwitch, .timingModeSelectA,
      .timingModeSelectB, .lineRxClk, .lineRxData, .lineTxClk, .lineTxData, .lineOctetTiming, .dmInBit,
      .dmInValid, .dmInReady, .dmOutBit, .dmOutValid, .activeMode);
   line_partner i_far (.lineRxClk, .lineRxData);
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      nTests++;
      if (seen !== exp)
      begin
         errCount++;
         $display("wrong value %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task completeRun();
      $display("checks %0d mismatches %0d", nTests, errCount);
      if (errCount == 0 && nTests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Sample at the falling edge so every output has settled
   always @(negedge ref_clk)
   begin
      if (dmOutValid)
         check("dmOutBit", 32'(dmOutBit), expDm.size() > 0 ? 32'(expDm.pop_front()) : 32'hx);
      if (lineTxClk && !txPrev && expLine.size() > 0)
         check("lineTxData", 32'(lineTxData), 32'(expLine.pop_front()));
      if (lineTxClk && !txPrev)
         txCount++;
      if (!lineTxClk && txPrev)
         check("lineOctetTiming", 32'(lineOctetTiming), 32'(octetTimingSwitch && txCount % 8 == 0 && txCount > 0));
      txPrev = lineTxClk;
   end
   initial
   begin
      #(60000 * 8);
      errCount++;
      completeRun();
   end
   initial
   begin
      logic b;
      int acc;
      {rst_n, dmInBit, dmInValid, octetTimingSwitch, timingModeSelectA, timingModeSelectB} = 6'h0;
      for (int m = 0; m < 4; m++)
      begin
         // Each mode starts off the clock edge, as all other stimulus does
         #1 rst_n = 1'b0;
         txCount = 0;
         {timingModeSelectB, timingModeSelectA} = 2'(m);
         octetTimingSwitch = !m[0];
         repeat (4) @(posedge ref_clk);
         #1 rst_n = 1'b1;
         repeat (4) @(posedge ref_clk);
         #1 check("activeMode", 32'(activeMode), m);
         acc = 0;
         // Offer up to ten bits or until the FIFO refuses; dual mode drains it every cycle
         for (int i = 0; i < 10 && dmInReady; i++)
         begin
            b = 1'($random(seed));
            dmInBit = b;
            dmInValid = 1'b1;
            if (m == 3) expDm.push_back(b);
            if (m < 2) expLine.push_back(b);
            acc++;
            @(posedge ref_clk);
            #1;
         end
         dmInValid = 1'b0;
         check("accepted", acc, m == 3 ? 10 : 8);
         if (m == 0) repeat (4) expLine.push_back(g703_pkg::IDLE_BIT);
         for (int i = 0; i < 12; i++)
         begin
            b = 1'($random(seed));
            if (m != 3) expDm.push_back(b);
            if (m > 1) expLine.push_back(b);
            i_far.send_bit(b);
         end
         i_far.end_frame();
         repeat (m == 1 ? 19600 : 40) @(posedge ref_clk);
         check("dm left", expDm.size(), 0);
         check("line left", expLine.size(), 0);
         $display("mode %0d done", m);
      end
      completeRun();
   end
endmodule // codirectional_64k_line_interface_test
